// [design/lut_pair_seq_defines.svh]
// Notes on behaviour
// - even table disabled clears the flip-flop output at once, without a clock edge.
// - the internal clear command lasts exactly one bus clock cycle.
// - with no clear active, flip-flop outputs change only on generic clock rising edges; latch outputs can change on any bus clock.
// - gated D: clear gives 0; gate 1 loads D; gate 0 holds.
// - JK mode takes J from the even table output.
// - JK mode takes K from the odd table output.
// - gated D takes D from even table output, gate from odd table output.
// - a per-pair select picks D flip-flop, JK flip-flop, gated D-latch or RS-latch.
`ifndef LUT_PAIR_SEQ_DEFINES_SVH
`define LUT_PAIR_SEQ_DEFINES_SVH

`define SEQ_SEL_DFF 2'h0
`define SEQ_SEL_JK 2'h1
`define SEQ_SEL_LATCH 2'h2
`define SEQ_SEL_RS 2'h3
`define SEQ_Q_RESET 1'h0
`define SEQ_CLEAR_VALUE 1'h0
`define SEQ_SET_VALUE 1'h1
`define SEQ_JK_HOLD 2'h0
`define SEQ_JK_CLEAR 2'h1
`define SEQ_JK_SET 2'h2
`define SEQ_JK_TOGGLE 2'h3
`define SEQ_ENABLE_PREV_RESET 1'h0
`define SEQ_GCLK_PREV_RESET 1'h0
`define SEQ_CLEAR_CMD_RESET 1'h0

`endif

// [design/lut_pair_seq_pkg.sv]
`include "lut_pair_seq_defines.svh"

package lut_pair_seq_pkg;

   // sequential type, one code per pair
   typedef enum logic [1:0] {
      seq_dff = `SEQ_SEL_DFF,
      seq_jk = `SEQ_SEL_JK,
      seq_latch = `SEQ_SEL_LATCH,
      seq_rs = `SEQ_SEL_RS
   } seq_mode_type;

   // outputs of the two lookup tables of the pair
   typedef struct packed {
      logic even_out;
      logic odd_out;
   } pair_in_type;

   // whole state of the element
   typedef struct packed {
      logic q;
      logic enable_prev;
      logic gclk_prev;
      logic clear_cmd;
   } state_type;

endpackage

// [design/lut_pair_sequential_element.sv]
`timescale 1ns/1ps
`include "lut_pair_seq_defines.svh"

module lut_pair_sequential_element (
   input wire logic clk, // peripheral bus clock, 25 MHz
   input wire logic rst_n, // asynchronous reset, active low
   input wire logic even_enable, // enable of the even lookup table
   input wire lut_pair_seq_pkg::seq_mode_type sequential_type_select, // element type
   input wire logic logic_array_gen_clock, // generic clock level, sampled on clk
   input wire lut_pair_seq_pkg::pair_in_type tables, // even and odd table outputs
   output logic seq_out, // element output
   output logic clear_cmd // internal clear pulse, one clk cycle
);
   import lut_pair_seq_pkg::*;

   state_type state_reg;
   state_type state_next;
   logic gclk_rise;
   logic data_in;
   logic ctrl_in;

   // the generic clock is sampled, so its rising edges become one-cycle enables;
   // it must stay below half the bus clock rate or edges are lost
   assign gclk_rise = logic_array_gen_clock & ~state_reg.gclk_prev;
   assign data_in = tables.even_out;
   assign ctrl_in = tables.odd_out;

   // all checks below run on the bus clock and rest during reset
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rst_n);

   // next state; latches follow their inputs every clk cycle, flip-flops only on edges
   always_comb begin
      state_next = state_reg;
      state_next.gclk_prev = logic_array_gen_clock;
      state_next.enable_prev = even_enable;
      // a falling enable launches the pulse; a low enable cannot launch another
      state_next.clear_cmd = state_reg.enable_prev & ~even_enable;
      if (!even_enable) begin
         state_next.q = `SEQ_CLEAR_VALUE;
      end else begin
         unique case (sequential_type_select)
            seq_dff: begin
               // gate from the odd table, data from the even table
               if (gclk_rise && ctrl_in) begin
                  state_next.q = data_in;
               end
            end
            seq_jk: begin
               if (gclk_rise) begin
                  unique case ({data_in, ctrl_in})
                     `SEQ_JK_HOLD: state_next.q = state_reg.q;
                     `SEQ_JK_CLEAR: state_next.q = `SEQ_CLEAR_VALUE;
                     `SEQ_JK_SET: state_next.q = `SEQ_SET_VALUE;
                     `SEQ_JK_TOGGLE: state_next.q = ~state_reg.q;
                  endcase
               end
            end
            seq_latch: begin
               // transparent while the gate is high, sampled once per bus clock
               if (ctrl_in) begin
                  state_next.q = data_in;
               end
            end
            seq_rs: begin
               // reset input dominates when both are high
               if (ctrl_in) begin
                  state_next.q = `SEQ_CLEAR_VALUE;
               end else if (data_in) begin
                  state_next.q = `SEQ_SET_VALUE;
               end
            end
         endcase
      end
   end

   // state register; enable_prev starts low so release never looks like a disable
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         state_reg.q <= `SEQ_Q_RESET;
         state_reg.enable_prev <= `SEQ_ENABLE_PREV_RESET;
         state_reg.gclk_prev <= `SEQ_GCLK_PREV_RESET;
         state_reg.clear_cmd <= `SEQ_CLEAR_CMD_RESET;
      end else begin
         state_reg <= state_next;
      end
   end

   // the gate makes the clear take effect in the same cycle the table drops its enable,
   // trading a pure register output for the asynchronous clear
   assign seq_out = state_reg.q & even_enable;
   assign clear_cmd = state_reg.clear_cmd;

   // clear path: the stored bit drops too, so a re-enable starts from zero
   // one cycle of low enable empties the stored bit, not only the output
   a_async_clear: assert property (
      !even_enable
      |=> state_reg.q == `SEQ_CLEAR_VALUE)
      else $error("stored bit not cleared while even table disabled");

   // the output stays low in the first enabled cycle
   a_reenable_low: assert property (
      $rose(even_enable)
      |-> !seq_out)
      else $error("output high right after the even table came back");

   // the stored bit is already cleared when enable returns
   a_reenable_clear: assert property (
      $rose(even_enable)
      |-> state_reg.q == `SEQ_CLEAR_VALUE)
      else $error("stored bit high right after the even table came back");

   // the clear pulse lasts a single bus clock
   a_clear_single: assert property (
      clear_cmd
      |=> !clear_cmd)
      else $error("clear command longer than one cycle");

   // every disable produces a pulse
   a_clear_cause: assert property (
      $fell(even_enable)
      |=> clear_cmd)
      else $error("clear command missing after disable");

   // no pulse while the table stays enabled
   a_clear_quiet: assert property (
      even_enable
      |=> !clear_cmd)
      else $error("clear command without a disable");

   // a pulse always traces back to an enable that just fell
   a_clear_needs_fall: assert property (
      clear_cmd
      |-> !$past(even_enable) && $past(even_enable, 2))
      else $error("clear command not preceded by a falling enable");

   // generic clock edges and the flip-flop timing they allow
   // the rise enable is a single-cycle pulse
   a_rise_single: assert property (
      gclk_rise
      |=> !gclk_rise)
      else $error("generic clock rise enable longer than one cycle");

   // both flip-flop types keep their state between generic clock rises
   a_ff_no_edge: assert property (
      even_enable && !gclk_rise
      && (sequential_type_select == seq_dff || sequential_type_select == seq_jk)
      |=> state_reg.q == $past(state_reg.q))
      else $error("flip-flop changed without a generic clock edge");

   // gated d flip-flop
   // an open gate at a rise loads the even table value
   a_dff_load: assert property (
      even_enable && sequential_type_select == seq_dff && gclk_rise && tables.odd_out
      |=> state_reg.q == $past(tables.even_out))
      else $error("gated d did not load data");

   // a closed gate holds the state, edge or no edge
   a_dff_gate_hold: assert property (
      even_enable && sequential_type_select == seq_dff && !tables.odd_out
      |=> $stable(state_reg.q))
      else $error("gated d changed with gate low");

   // jk flip-flop, one check per input pair
   // both inputs low hold
   a_jk_hold: assert property (
      even_enable && sequential_type_select == seq_jk && gclk_rise
      && !tables.even_out && !tables.odd_out
      |=> $stable(state_reg.q))
      else $error("jk did not hold");

   // j alone sets
   a_jk_set: assert property (
      even_enable && sequential_type_select == seq_jk && gclk_rise
      && tables.even_out && !tables.odd_out
      |=> state_reg.q)
      else $error("jk did not set");

   // k alone clears
   a_jk_clear: assert property (
      even_enable && sequential_type_select == seq_jk && gclk_rise
      && !tables.even_out && tables.odd_out
      |=> !state_reg.q)
      else $error("jk did not clear");

   // both high toggle
   a_jk_toggle: assert property (
      even_enable && sequential_type_select == seq_jk && gclk_rise
      && tables.even_out && tables.odd_out
      |=> state_reg.q != $past(state_reg.q))
      else $error("jk did not toggle");

   // gated latch, no generic clock involved
   // an open gate passes the even table value
   a_latch_follow: assert property (
      even_enable && sequential_type_select == seq_latch && tables.odd_out
      |=> state_reg.q == $past(tables.even_out))
      else $error("latch did not follow data");

   // a closed gate holds
   a_latch_hold: assert property (
      even_enable && sequential_type_select == seq_latch && !tables.odd_out
      |=> $stable(state_reg.q))
      else $error("latch changed with gate low");

   // rs latch, reset dominant
   // reset high clears, whatever set does
   a_rs_reset: assert property (
      even_enable && sequential_type_select == seq_rs && tables.odd_out
      |=> !state_reg.q)
      else $error("rs latch did not reset");

   // set alone sets
   a_rs_set: assert property (
      even_enable && sequential_type_select == seq_rs && !tables.odd_out && tables.even_out
      |=> state_reg.q)
      else $error("rs latch did not set");

   // both low hold
   a_rs_hold: assert property (
      even_enable && sequential_type_select == seq_rs && !tables.odd_out && !tables.even_out
      |=> $stable(state_reg.q))
      else $error("rs latch changed with both inputs low");
endmodule

// [dv/lut_pair_model.sv]
`timescale 1ns/1ps
module lut_pair_model (
   input wire logic even_val, // even table result
   input wire logic odd_val, // odd table result
   output lut_pair_seq_pkg::pair_in_type tables // pair outputs to the element
);
   import lut_pair_seq_pkg::*;
   // plain table logic: no storage, follows its inputs at once
   assign tables = '{even_out: even_val, odd_out: odd_val};
endmodule

// [dv/tb_lut_pair_sequential_element.sv]
`timescale 1ns/1ps
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin err_count++; \
   $display("[FAIL] %0t %h %h", $time, a, b); end end
module tb_lut_pair_sequential_element;
   import lut_pair_seq_pkg::*;
   logic clk = 1'h0, rst_n = 1'h0, en = 1'h0, gclk = 1'h0, ev = 1'h0, od = 1'h0;
   seq_mode_type mode = seq_dff;
   pair_in_type tables;
   logic seq_out, clear_cmd;
   int err_count = 0, samples_checked = 0;
   lut_pair_model partner (.even_val(ev), .odd_val(od), .tables(tables));
   lut_pair_sequential_element dut (.clk(clk), .rst_n(rst_n), .even_enable(en),
      .sequential_type_select(mode), .logic_array_gen_clock(gclk), .tables(tables),
      .seq_out(seq_out), .clear_cmd(clear_cmd));
   initial begin
      forever #20 clk = ~clk;
   end
   // one generic clock rise carrying the given table values, then compare
   task automatic edge_chk(input logic e, input logic o, input logic exp);
      @(posedge clk);
      ev <= e;
      od <= o;
      gclk <= 1'h1;
      @(posedge clk);
      gclk <= 1'h0;
      #1 `CHK(seq_out, exp)
   endtask
   task automatic dff_test;
      edge_chk(1'h1, 1'h1, 1'h1);
      edge_chk(1'h0, 1'h0, 1'h1);
      edge_chk(1'h0, 1'h1, 1'h0);
      edge_chk(1'h1, 1'h1, 1'h1);
      // gate open and data low, but no generic clock rise: must hold
      @(posedge clk);
      ev <= 1'h0;
      repeat (3) @(posedge clk);
      #1 `CHK(seq_out, 1'h1)
   endtask
   task automatic clear_test;
      @(posedge clk);
      en <= 1'h0;
      #1 `CHK(seq_out, 1'h0)
      @(posedge clk);
      #1 `CHK(clear_cmd, 1'h1)
      @(posedge clk);
      #1 `CHK(clear_cmd, 1'h0)
      @(posedge clk);
      mode <= seq_jk;
      @(posedge clk);
      en <= 1'h1;
      #1 `CHK(seq_out, 1'h0)
   endtask
   // disable, switch type, enable again, as software must around a change
   task automatic reconfigure(input seq_mode_type m);
      @(posedge clk);
      en <= 1'h0;
      @(posedge clk);
      mode <= m;
      @(posedge clk);
      en <= 1'h1;
   endtask
   // gated latch: follows data every bus clock while the gate is high
   task automatic latch_test;
      reconfigure(seq_latch);
      ev <= 1'h1;
      od <= 1'h1;
      @(posedge clk);
      #1 `CHK(seq_out, 1'h1)
      @(posedge clk);
      ev <= 1'h0;
      od <= 1'h0;
      @(posedge clk);
      #1 `CHK(seq_out, 1'h1)
      @(posedge clk);
      od <= 1'h1;
      @(posedge clk);
      #1 `CHK(seq_out, 1'h0)
   endtask
   // rs latch: set, hold, then reset winning over set
   task automatic rs_test;
      reconfigure(seq_rs);
      ev <= 1'h1;
      od <= 1'h0;
      @(posedge clk);
      #1 `CHK(seq_out, 1'h1)
      @(posedge clk);
      ev <= 1'h0;
      @(posedge clk);
      #1 `CHK(seq_out, 1'h1)
      @(posedge clk);
      ev <= 1'h1;
      od <= 1'h1;
      @(posedge clk);
      #1 `CHK(seq_out, 1'h0)
   endtask
   // release from reset: output low and no clear pulse
   task automatic reset_test;
      repeat (2) @(posedge clk);
      rst_n <= 1'h1;
      #1 `CHK({seq_out, clear_cmd}, 2'h0)
      @(posedge clk);
      en <= 1'h1;
      #1 `CHK(clear_cmd, 1'h0)
   endtask
   task automatic jk_test;
      edge_chk(1'h1, 1'h0, 1'h1);
      edge_chk(1'h0, 1'h0, 1'h1);
      edge_chk(1'h1, 1'h1, 1'h0);
      edge_chk(1'h1, 1'h1, 1'h1);
      edge_chk(1'h0, 1'h1, 1'h0);
   endtask
   task automatic print_verdict;
      if (err_count == 0 && samples_checked > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask
   // a full run needs well under a hundred cycles; this bound only cuts a hang
   initial begin
      #100000;
      err_count++;
      print_verdict();
   end
   initial begin
      reset_test();
      dff_test();
      clear_test();
      jk_test();
      latch_test();
      rs_test();
      print_verdict();
   end
endmodule
